//--- design/quadrature_sincos_output.sv
// sine/cosine output stage with format, serial and phase test modes
//
// Summary of operation
// - look up sine and cosine from top 20 phase bits, two 16-bit words
// - 20-bit address spans one turn, zero is 0 rad
// - vector error below -90.2dB, each component about 2dB better
// - offset binary off gives two's complement words centred on zero
// - offset binary on inverts msb of both words only
// - codes symmetric, 8001..7fff or 0001..ffff
// - serial select switches outputs to serial bit streams
// - load enable loads shift registers, then one bit shifts per clock
// - msb-first stream on each channel's bit 15 pin
// - lsb-first stream on each channel's bit 0 pin
// - msb-first stream gives zeros after last bit
// - lsb-first stream repeats sign bit after top bit
// - strobe pulses when first bit of new serial word is valid
// - test and serial select high put top 28 phase bits out
// - sine bus holds top 16 phase bits, cosine upper twelve the rest
// - test select sampled synchronously, whole cycles only
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/100ps
`include "qs_map.svh"
module quadrature_sincos_output
  import qs_pkg::*;
#(
  parameter int PHASE_W = 28,
  parameter int ADDR_W  = 8
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  input  wire logic [PHASE_W-1:0] phase_in,
  input  wire logic               accum_shift_load_en_n,
  input  wire logic               offset_binary_sel,
  input  wire logic               serial_out_sel,
  input  wire logic               test_sel,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic      [15:0]        sine_out,
  output logic      [15:0]        cosine_out,
  output logic                    word_start_strobe
);
  localparam int LAT = `QS_LOOKUP_LAT;
  localparam int TW  = `QS_TEST_W;

  // ------------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------------
  if (PHASE_W < TW) begin : g_phase_chk
    $error("phase input narrower than the test bus");
  end
  if (ADDR_W < 4) begin : g_addr_chk
    $error("address too narrow for the register map");
  end

  typedef struct packed {
    logic [LAT-1:0][PHASE_W-1:0] ph;
    logic [15:0]                 msb_sin;
    logic [15:0]                 msb_cos;
    logic [15:0]                 lsb_sin;
    logic [15:0]                 lsb_cos;
    logic [4:0]                  cnt;
    logic [`QS_CTRL_W-1:0]       ctrl;
    logic [31:0]                 smpl;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    logic [15:0]                 sine_out;
    logic [15:0]                 cosine_out;
    logic                        strobe;
  } out_s;

  out_s      s;
  out_s      next_s;
  out_mode_e mode;
  logic      obin;
  logic      ser_on;
  logic      test_on;
  logic      load;
  logic [15:0] sin_lk;
  logic [15:0] cos_lk;
  logic [15:0] sin_f;
  logic [15:0] cos_f;
  logic [TW-1:0] ph_top;

  // ------------------------------------------------------------------
  // lookup
  // ------------------------------------------------------------------
  sincos_lookup u_lookup (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .phase_addr (phase_in[PHASE_W-1 -: `QS_LUT_W]),
    .sin_v      (sin_lk),
    .cos_v      (cos_lk)
  );

  // ------------------------------------------------------------------
  // mode and format
  // ------------------------------------------------------------------
  always_comb begin
    obin    = offset_binary_sel | s.ctrl[`QS_CTRL_OBIN];
    ser_on  = serial_out_sel | s.ctrl[`QS_CTRL_SER];
    test_on = (test_sel | s.ctrl[`QS_CTRL_TEST]) & ser_on;
    load    = ~accum_shift_load_en_n;
    ph_top  = s.ph[LAT-1][PHASE_W-1 -: TW];
    sin_f   = obin ? (sin_lk ^ `QS_MSB_MASK) : sin_lk;
    cos_f   = obin ? (cos_lk ^ `QS_MSB_MASK) : cos_lk;
    if (test_on) mode = MODE_TEST;
    else if (ser_on) mode = MODE_SER;
    else mode = MODE_PAR;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (clk_en) begin
      // phase delay matches the lookup latency so test data lines up
      next_s.ph[0] = phase_in;
      for (int k = 1; k < LAT; k++) next_s.ph[k] = s.ph[k-1];
      next_s.smpl = {cos_f, sin_f};
      // --------------------------------------------------------------
      // serial shift registers
      // --------------------------------------------------------------
      if (load) begin
        next_s.msb_sin = sin_f;
        next_s.msb_cos = cos_f;
        next_s.lsb_sin = sin_f;
        next_s.lsb_cos = cos_f;
        next_s.cnt     = '0;
      end else begin
        next_s.msb_sin = {s.msb_sin[14:0], 1'b0};
        next_s.msb_cos = {s.msb_cos[14:0], 1'b0};
        next_s.lsb_sin = {s.lsb_sin[15], s.lsb_sin[15:1]};
        next_s.lsb_cos = {s.lsb_cos[15], s.lsb_cos[15:1]};
        if (s.cnt != `QS_WORD_BITS) next_s.cnt = s.cnt + 5'd1;
      end
      next_s.strobe = 1'b0;
      case (mode)
        MODE_TEST: begin
          next_s.sine_out   = ph_top[TW-1 -: 16];
          next_s.cosine_out = {ph_top[TW-17:0], 4'h0};
        end
        MODE_SER: begin
          next_s.sine_out   = {next_s.msb_sin[15], 14'h0, next_s.lsb_sin[0]};
          next_s.cosine_out = {next_s.msb_cos[15], 14'h0, next_s.lsb_cos[0]};
          next_s.strobe     = load;
        end
        default: begin
          next_s.sine_out   = sin_f;
          next_s.cosine_out = cos_f;
        end
      endcase
      // --------------------------------------------------------------
      // apb: answer one cycle into the access phase
      // --------------------------------------------------------------
      next_s.pready  = psel & penable & ~s.pready;
      next_s.pslverr = 1'b0;
      if (psel & penable & ~s.pready) begin
        next_s.prdata = '0;
        if (paddr == ADDR_W'(`QS_CTRL_OFF))
          next_s.prdata = 32'(s.ctrl);
        else if (paddr == ADDR_W'(`QS_STAT_OFF))
          next_s.prdata = 32'({s.cnt, 1'b0, test_on, ser_on, obin});
        else if (paddr == ADDR_W'(`QS_SMPL_OFF))
          next_s.prdata = s.smpl;
        else
          next_s.pslverr = 1'b1;
        if (pwrite) next_s.prdata = '0;
      end
      if (psel & penable & s.pready & pwrite & ~s.pslverr &
          paddr == ADDR_W'(`QS_CTRL_OFF))
        next_s.ctrl = pwdata[`QS_CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s      <= '0;
      s.ctrl <= `QS_CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata            = s.prdata;
  assign pready            = s.pready;
  assign pslverr           = s.pslverr;
  assign sine_out          = s.sine_out;
  assign cosine_out        = s.cosine_out;
  assign word_start_strobe = s.strobe;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_obin_msb_flip: assert property (
    $past(clk_en) && $past(mode) == MODE_PAR |->
      sine_out == ($past(sin_lk) ^ ($past(obin) ? `QS_MSB_MASK : 16'h0)) &&
      cosine_out == ($past(cos_lk) ^ ($past(obin) ? `QS_MSB_MASK : 16'h0)))
    else $error("parallel word not formatted from lookup");
  a_code_range: assert property (
    $past(clk_en) && $past(mode) == MODE_PAR |->
      sine_out != ($past(obin) ? 16'h0 : `QS_MSB_MASK))
    else $error("sine code outside symmetric range");
  a_load_strobe: assert property (
    clk_en && mode == MODE_SER && load |=>
      word_start_strobe && sine_out[15] == $past(sin_f[15]) &&
      cosine_out[0] == $past(cos_f[0]))
    else $error("serial load without strobe or first bit");
  a_strobe_single: assert property (
    word_start_strobe && clk_en && !load |=> !word_start_strobe)
    else $error("strobe longer than one cycle");
  a_msb_stream: assert property (
    clk_en && mode == MODE_SER && !load |=>
      sine_out[15] == $past(s.msb_sin[14]) && cosine_out[15] == $past(s.msb_cos[14]))
    else $error("msb-first stream out of order");
  a_lsb_stream: assert property (
    clk_en && mode == MODE_SER && !load |=>
      sine_out[0] == $past(s.lsb_sin[1]) && cosine_out[0] == $past(s.lsb_cos[1]))
    else $error("lsb-first stream out of order");
  a_msb_zero_fill: assert property (
    s.cnt == `QS_WORD_BITS |-> s.msb_sin == '0 && s.msb_cos == '0)
    else $error("msb-first stream not zero after word");
  a_lsb_sign_fill: assert property (
    s.cnt >= `QS_SIGN_FILL |->
      s.lsb_sin == {16{s.lsb_sin[15]}} && s.lsb_cos == {16{s.lsb_cos[15]}})
    else $error("lsb-first stream not sign filled");
  a_test_phase_bus: assert property (
    $past(clk_en) && $past(mode) == MODE_TEST |->
      sine_out == $past(ph_top[TW-1 -: 16]) &&
      cosine_out[15:4] == $past(ph_top[TW-17:0]) && !word_start_strobe)
    else $error("test bus does not show phase");

  // ------------------------------------------------------------------
  // serial, code range and freeze checks
  // ------------------------------------------------------------------
  a_ser_mid_zero: assert property (
    $past(clk_en) && $past(mode) == MODE_SER |->
      sine_out[14:1] == '0 && cosine_out[14:1] == '0)
    else $error("serial bus middle bits not zero");
  a_load_restart: assert property (
    clk_en && load |=>
      s.cnt == '0 && s.msb_sin == $past(sin_f) && s.lsb_cos == $past(cos_f))
    else $error("load did not restart the word");
  a_cnt_bound: assert property (
    s.cnt <= `QS_WORD_BITS)
    else $error("bit counter past word length");
  a_strobe_ser_only: assert property (
    $past(clk_en) && $past(mode) != MODE_SER |-> !word_start_strobe)
    else $error("strobe outside serial mode");
  a_cos_range: assert property (
    $past(clk_en) && $past(mode) == MODE_PAR |->
      cosine_out != ($past(obin) ? 16'h0 : `QS_MSB_MASK))
    else $error("cosine code outside symmetric range");
  a_freeze_hold: assert property (
    !clk_en |=> $stable(sine_out) && $stable(cosine_out) &&
      $stable(word_start_strobe) && $stable(prdata) && $stable(pready))
    else $error("outputs moved while clock enable low");

  // ------------------------------------------------------------------
  // bus checks
  // ------------------------------------------------------------------
  a_pready_rise: assert property (
    clk_en && psel && penable && !pready |=> pready)
    else $error("access phase not answered");
  a_pready_fall: assert property (
    clk_en && pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (
    clk_en && psel && penable && !pready && paddr != ADDR_W'(`QS_CTRL_OFF) &&
      paddr != ADDR_W'(`QS_STAT_OFF) && paddr != ADDR_W'(`QS_SMPL_OFF) |=> pslverr)
    else $error("unmapped address not refused");
  a_err_no_write: assert property (
    clk_en && pready && pslverr |=> $stable(s.ctrl))
    else $error("refused write changed control");
  a_ctrl_write: assert property (
    clk_en && psel && penable && pready && pwrite && !pslverr &&
      paddr == ADDR_W'(`QS_CTRL_OFF) |=> s.ctrl == $past(pwdata[`QS_CTRL_W-1:0]))
    else $error("control write lost");
  a_write_rdata_zero: assert property (
    pready && $past(pwrite) |-> prdata == '0)
    else $error("write returned read data");

  c_serial_word: cover property (load && mode == MODE_SER ##1 !load [*8]);
  c_test_mode: cover property (mode == MODE_TEST ##1 mode == MODE_PAR);
  c_obin_par: cover property (mode == MODE_PAR && obin && clk_en);
  c_apb_error: cover property (pready && pslverr);
  c_freeze: cover property (!clk_en ##1 clk_en);
endmodule // quadrature_sincos_output

//--- design/qs_map.svh
// constants of the quadrature sine/cosine output stage
`ifndef QS_MAP_SVH
`define QS_MAP_SVH
// ------------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------------
`define QS_CTRL_OFF   8'h00
`define QS_STAT_OFF   8'h04
`define QS_SMPL_OFF   8'h08
// ------------------------------------------------------------------
// fields and values
// ------------------------------------------------------------------
`define QS_CTRL_OBIN  0
`define QS_CTRL_SER   1
`define QS_CTRL_TEST  2
`define QS_CTRL_W     3
`define QS_CTRL_RST   3'h0
`define QS_MSB_MASK   16'h8000
`define QS_WORD_BITS  5'd16
`define QS_SIGN_FILL  5'd15
`define QS_TEST_W     28
`define QS_LUT_W      20
`define QS_AMP_W      16
`define QS_ITER       16
`define QS_LOOKUP_LAT 18
`define QS_FRAC_BITS  4
`define QS_RND_HALF   8
`define QS_AMP_MAX    32767
`define QS_CORDIC_X0  318366
`define QS_AMP_TOL    2
`endif

//--- design/qs_pkg.sv
// types shared by the quadrature sine/cosine output stage
package qs_pkg;
  typedef enum logic [1:0] {MODE_PAR, MODE_SER, MODE_TEST} out_mode_e;
endpackage

//--- design/sincos_lookup.sv
// pipelined sine/cosine generator from a 20-bit phase address
`timescale 1ns/100ps
`include "qs_map.svh"
module sincos_lookup
  import qs_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  input  wire logic [`QS_LUT_W-1:0] phase_addr,
  output logic      [`QS_AMP_W-1:0] sin_v,
  output logic      [`QS_AMP_W-1:0] cos_v
);
  localparam int IT  = `QS_ITER;
  localparam int XW  = 22;
  localparam int ZW  = 21;
  localparam int LAT = `QS_LOOKUP_LAT;
  localparam logic signed [XW-1:0] AMAX = XW'(`QS_AMP_MAX);
  // arctan(2^-i) in units of one turn / 2^20
  localparam logic [17:0] ATAN [IT] = '{
    18'd131072, 18'd77376, 18'd40884, 18'd20753, 18'd10417, 18'd5213,
    18'd2607, 18'd1304, 18'd652, 18'd326, 18'd163, 18'd81, 18'd41,
    18'd20, 18'd10, 18'd5};

  typedef struct packed {
    logic [IT:0][XW-1:0] x;
    logic [IT:0][XW-1:0] y;
    logic [IT:0][ZW-1:0] z;
    logic [IT:0][1:0]    q;
    logic [15:0]         sin_v;
    logic [15:0]         cos_v;
    logic [4:0]          run;
  } cordic_s;

  cordic_s s;
  cordic_s next_s;

  function automatic logic [15:0] sat(input logic [XW-1:0] v);
    logic signed [XW-1:0] r;
    r = $signed(XW'(($signed(v) + XW'(`QS_RND_HALF)) >>> `QS_FRAC_BITS));
    if (r > AMAX) return AMAX[15:0];
    else if (r < -AMAX) return 16'(-AMAX);
    else return r[15:0];
  endfunction

  always_comb begin
    logic [15:0] c;
    logic [15:0] sv;
    c      = '0;
    sv     = '0;
    next_s = s;
    if (clk_en) begin
      // quadrant split keeps the residual inside the cordic range
      next_s.x[0] = XW'(`QS_CORDIC_X0);
      next_s.y[0] = '0;
      next_s.z[0] = ZW'(phase_addr[`QS_LUT_W-3:0]);
      next_s.q[0] = phase_addr[`QS_LUT_W-1 -: 2];
      for (int i = 0; i < IT; i++) begin
        if (!s.z[i][ZW-1]) begin
          next_s.x[i+1] = XW'($signed(s.x[i]) - ($signed(s.y[i]) >>> i));
          next_s.y[i+1] = XW'($signed(s.y[i]) + ($signed(s.x[i]) >>> i));
          next_s.z[i+1] = s.z[i] - ZW'(ATAN[i]);
        end else begin
          next_s.x[i+1] = XW'($signed(s.x[i]) + ($signed(s.y[i]) >>> i));
          next_s.y[i+1] = XW'($signed(s.y[i]) - ($signed(s.x[i]) >>> i));
          next_s.z[i+1] = s.z[i] + ZW'(ATAN[i]);
        end
        next_s.q[i+1] = s.q[i];
      end
      c  = sat(s.x[IT]);
      sv = sat(s.y[IT]);
      case (s.q[IT])
        2'd0: begin next_s.cos_v = c;          next_s.sin_v = sv;          end
        2'd1: begin next_s.cos_v = 16'h0 - sv; next_s.sin_v = c;           end
        2'd2: begin next_s.cos_v = 16'h0 - c;  next_s.sin_v = 16'h0 - sv;  end
        default: begin next_s.cos_v = sv;      next_s.sin_v = 16'h0 - c;   end
      endcase
      if (s.run != 5'(LAT)) next_s.run = s.run + 5'd1;
    end else begin
      next_s.run = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s <= '0;
    else s <= next_s;
  end

  assign sin_v = s.sin_v;
  assign cos_v = s.cos_v;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_zero_phase: assert property (@(posedge pclk) disable iff (!presetn)
    s.run == 5'(LAT) && $past(phase_addr, LAT) == '0 |->
      $signed(cos_v) >= $signed(16'(`QS_AMP_MAX - `QS_AMP_TOL)) &&
      $signed(sin_v) <= $signed(16'(`QS_AMP_TOL)) &&
      $signed(sin_v) >= -$signed(16'(`QS_AMP_TOL)))
    else $error("zero phase gives wrong vector");
  a_quarter_turn: assert property (@(posedge pclk) disable iff (!presetn)
    s.run == 5'(LAT) && $past(phase_addr, LAT) == 20'h40000 |->
      $signed(sin_v) >= $signed(16'(`QS_AMP_MAX - `QS_AMP_TOL)) &&
      $signed(cos_v) <= $signed(16'(`QS_AMP_TOL)) &&
      $signed(cos_v) >= -$signed(16'(`QS_AMP_TOL)))
    else $error("quarter turn gives wrong vector");
  a_no_neg_full: assert property (@(posedge pclk) disable iff (!presetn)
    sin_v != `QS_MSB_MASK && cos_v != `QS_MSB_MASK)
    else $error("amplitude reached 8000");
endmodule // sincos_lookup

//--- verification/dac_model.sv
// serial converter pair model assembling msb-first and lsb-first words
`timescale 1ns/100ps
module dac_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] sine_out,
  input  wire logic [15:0] cosine_out,
  input  wire logic        word_start_strobe,
  output logic      [15:0] sin_msb_w,
  output logic      [15:0] sin_lsb_w,
  output logic      [15:0] cos_msb_w,
  output logic      [15:0] cos_lsb_w,
  output logic      [4:0]  bit_cnt
);
  // strobe restarts both words, then sixteen bits are taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_msb_w <= 16'h0000;
      sin_lsb_w <= 16'h0000;
      cos_msb_w <= 16'h0000;
      cos_lsb_w <= 16'h0000;
      bit_cnt   <= 5'h00;
    end else if (word_start_strobe || bit_cnt < 5'h10) begin
      sin_msb_w <= {(word_start_strobe ? 15'h0000 : sin_msb_w[14:0]), sine_out[15]};
      cos_msb_w <= {(word_start_strobe ? 15'h0000 : cos_msb_w[14:0]), cosine_out[15]};
      sin_lsb_w <= {sine_out[0], (word_start_strobe ? 15'h0000 : sin_lsb_w[15:1])};
      cos_lsb_w <= {cosine_out[0], (word_start_strobe ? 15'h0000 : cos_lsb_w[15:1])};
      bit_cnt   <= word_start_strobe ? 5'h01 : bit_cnt + 5'h01;
    end
  end
endmodule // dac_model

//--- verification/testbench.sv
// self-checking bench of the sine/cosine output stage
`timescale 1ns/100ps
`include "qs_map.svh"
module testbench
  import qs_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [27:0] phase_in = 28'h0;
  logic        load_n = 1'b1;
  logic        obin = 1'b0;
  logic        ser = 1'b0;
  logic        tst = 1'b0;
  logic        en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] sine_out;
  logic [15:0] cosine_out;
  logic        strobe;
  logic [15:0] smw, slw, cmw, clw;
  logic [4:0]  bcnt;
  logic [31:0] rd;
  logic        er;
  logic [27:0] p;
  logic [15:0] es, ec, m;
  int          failures = 0;
  int          num_checks = 0;
  logic [27:0] ser_tab [4] = '{28'h1555555, 28'h6aaaaaa, 28'ha000000, 28'he000000};

  always #2.5 pclk = ~pclk;

  quadrature_sincos_output dut_u (.pclk(pclk), .presetn(presetn), .clk_en(en),
    .phase_in(phase_in), .accum_shift_load_en_n(load_n), .offset_binary_sel(obin),
    .serial_out_sel(ser), .test_sel(tst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sine_out(sine_out), .cosine_out(cosine_out), .word_start_strobe(strobe));
  dac_model dac_u (.pclk(pclk), .presetn(presetn), .sine_out(sine_out),
    .cosine_out(cosine_out), .word_start_strobe(strobe), .sin_msb_w(smw),
    .sin_lsb_w(slw), .cos_msb_w(cmw), .cos_lsb_w(clw), .bit_cnt(bcnt));

  task automatic stop_test();
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // tol 0 asks for exact match, else modulo-16-bit distance
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol);
    int d;
    num_checks++;
    d = int'($signed(16'(seen[15:0] - exp[15:0])));
    if ((tol == 0) ? (seen !== exp) : ($isunknown(seen) || d > tol || d < -tol)) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] amp(input logic [27:0] ph, input bit c);
    real a;
    real r;
    a = 6.283185307179586 * ph[27:8] / 1048576.0;
    r = 32767.0 * (c ? $cos(a) : $sin(a));
    return 16'($rtoi(r + (r >= 0.0 ? 0.5 : -0.5)));
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      stop_test();
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  initial begin
    void'($urandom(30));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    apb(1'b0, `QS_CTRL_OFF, 32'h0, rd, er);
    check(rd, 32'h0, 0);
    apb(1'b1, `QS_CTRL_OFF, 32'h5, rd, er);
    apb(1'b0, `QS_CTRL_OFF, 32'h0, rd, er);
    check(rd, 32'h5, 0);
    apb(1'b0, `QS_STAT_OFF, 32'h0, rd, er);
    check(rd & 32'hf, 32'h1, 0);
    apb(1'b1, 8'h0c, 32'h7, rd, er);
    check({31'h0, er}, 32'h1, 0);
    check(rd, 32'h0, 0);
    apb(1'b1, `QS_CTRL_OFF, 32'h0, rd, er);
    // ----------------------------------------------------------------
    // parallel words, corners then random phases
    // ----------------------------------------------------------------
    for (int i = 0; i < 12; i++) begin
      p = (i < 4) ? 28'(i) << 26 : 28'($urandom);
      @(posedge pclk);
      phase_in <= p;
      obin <= i[0];
      wait_cyc(21);
      m = i[0] ? `QS_MSB_MASK : 16'h0;
      es = amp(p, 1'b0) ^ m;
      ec = amp(p, 1'b1) ^ m;
      check({16'h0, sine_out}, {16'h0, es}, `QS_AMP_TOL);
      check({16'h0, cosine_out}, {16'h0, ec}, `QS_AMP_TOL);
      check({31'h0, sine_out === (m ^ 16'h8000)}, 32'h0, 0);
      check({31'h0, cosine_out === (m ^ 16'h8000)}, 32'h0, 0);
      apb(1'b0, `QS_SMPL_OFF, 32'h0, rd, er);
      check({16'h0, rd[15:0]}, {16'h0, es}, `QS_AMP_TOL);
      check({16'h0, rd[31:16]}, {16'h0, ec}, `QS_AMP_TOL);
    end
    // frozen clock enable holds the last word
    @(posedge pclk);
    en <= 1'b0;
    phase_in <= ~p;
    wait_cyc(4);
    check({16'h0, sine_out}, {16'h0, es}, `QS_AMP_TOL);
    check({16'h0, cosine_out}, {16'h0, ec}, `QS_AMP_TOL);
    @(posedge pclk);
    en <= 1'b1;
    // ----------------------------------------------------------------
    // serial words and tails
    // ----------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      p = ser_tab[i];
      @(posedge pclk);
      phase_in <= p;
      ser <= 1'b1;
      obin <= i[0];
      wait_cyc(21);
      m = i[0] ? `QS_MSB_MASK : 16'h0;
      es = amp(p, 1'b0) ^ m;
      ec = amp(p, 1'b1) ^ m;
      @(posedge pclk);
      load_n <= 1'b0;
      @(posedge pclk);
      load_n <= 1'b1;
      #1;
      check({31'h0, strobe}, 32'h1, 0);
      wait_cyc(1);
      check({31'h0, strobe}, 32'h0, 0);
      wait_cyc(15);
      check({16'h0, smw}, {16'h0, es}, `QS_AMP_TOL);
      check({16'h0, cmw}, {16'h0, ec}, `QS_AMP_TOL);
      check({16'h0, slw}, {16'h0, es}, `QS_AMP_TOL);
      check({16'h0, clw}, {16'h0, ec}, `QS_AMP_TOL);
      repeat (2) begin
        check({30'h0, sine_out[15], cosine_out[15]}, 32'h0, 0);
        check({30'h0, sine_out[0], cosine_out[0]}, {30'h0, es[15], ec[15]}, 0);
        wait_cyc(1);
      end
    end
    // ----------------------------------------------------------------
    // phase test mode, by register then by pins
    // ----------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `QS_CTRL_OFF, (i == 0) ? 32'h6 : 32'h0, rd, er);
      p = 28'($urandom);
      phase_in <= p;
      ser <= i[0];
      tst <= i[0];
      wait_cyc(21);
      check({16'h0, sine_out}, {16'h0, p[27:12]}, 0);
      check({16'h0, cosine_out}, {16'h0, p[11:0], 4'h0}, 0);
    end
    stop_test();
  end
endmodule // testbench
